// ===== logic/thermal_misc_ctrl.sv
// Operation
// - mode select bit picks duty or step
// - thermal enable clear disables both mechanisms
// - prefetch disable bit stops stream prefetch
// - error pin mux bit selects break signalling
// - step throttle applies last written setting
// - step enable clear keeps ratio unchanged
// - availability bits are fixed read only
module thermal_misc_ctrl
   import thermal_misc_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [13:0] ADDR,
   input wire logic [63:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic THERM_HOT,
   input wire logic BREAK_PENDING,
   input wire logic LEGACY_FP_ERR,
   output logic [63:0] RDATA,
   output logic PREFETCH_EN,
   output logic FLOAT_ERROR_PIN,
   output logic DUTY_THROTTLE,
   output logic STEP_THROTTLE,
   output logic [15:0] STEP_SETTING,
   output logic FAST_STRINGS
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      ctrl_t ctrl;
      logic [63:0] rdata;
      logic prefetch_en;
      logic float_error_pin;
      logic duty;
      logic step;
      logic [15:0] step_out;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   reg_req_t req;
   throttle_t mode;
   logic duty_act;
   logic step_act;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // readback image of the feature register, fixed bits included
   function automatic logic [63:0] misc_image(input ctrl_t c);
      logic [63:0] v;
      v = MISC_RO_VALUE;
      v[FAST_STR_BIT] = c.fast_strings;
      v[AUTO_THERM_BIT] = c.auto_thermal_en;
      v[PREFETCH_DIS_BIT] = c.prefetch_dis;
      v[FLOAT_ERROR_PIN_MUX_BIT] = c.float_error_pin_mux;
      v[FREQ_STEP_EN_BIT] = c.freq_step_en;
      return v;
   endfunction

   throttle_select u_sel (
      .clk(CLK),
      .nrst(NRST),
      .ctrl(s_r.ctrl),
      .hot(THERM_HOT),
      .mode(mode),
      .duty_active(duty_act),
      .step_active(step_act)
   );

   // ----------------------------------------------------------------
   // register access and outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rdata = 64'h0000_0000_0000_0000;
      // writes touch only defined fields; reserved bits are dropped
      if (req.wr && req.addr == THERM_CTL_ADDR)
      begin
         s_nxt.ctrl.mode_select = req.wdata[MODE_SEL_BIT];
         s_nxt.ctrl.step_setting = req.wdata[STEP_SET_MSB:0];
      end
      else if (req.wr && req.addr == MISC_EN_ADDR)
      begin
         s_nxt.ctrl.fast_strings = req.wdata[FAST_STR_BIT];
         s_nxt.ctrl.auto_thermal_en = req.wdata[AUTO_THERM_BIT];
         s_nxt.ctrl.prefetch_dis = req.wdata[PREFETCH_DIS_BIT];
         s_nxt.ctrl.float_error_pin_mux = req.wdata[FLOAT_ERROR_PIN_MUX_BIT];
         s_nxt.ctrl.freq_step_en = req.wdata[FREQ_STEP_EN_BIT];
      end
      // read decode; unmapped addresses return zero
      if (req.rd && req.addr == THERM_CTL_ADDR)
      begin
         s_nxt.rdata[MODE_SEL_BIT] = s_r.ctrl.mode_select;
         s_nxt.rdata[STEP_SET_MSB:0] = s_r.ctrl.step_setting;
      end
      else if (req.rd && req.addr == MISC_EN_ADDR)
      begin
         s_nxt.rdata = misc_image(s_r.ctrl);
      end
      else if (req.rd && req.addr == SENSOR_ADDR)
      begin
         // live throttle state, handy when tuning the trip point
         s_nxt.rdata[1:0] = mode;
         s_nxt.rdata[2] = duty_act;
         s_nxt.rdata[3] = step_act;
      end
      s_nxt.prefetch_en = !s_r.ctrl.prefetch_dis;
      // pin follows break events only in mux mode
      s_nxt.float_error_pin = s_r.ctrl.float_error_pin_mux ? BREAK_PENDING : LEGACY_FP_ERR;
      s_nxt.duty = duty_act;
      s_nxt.step = step_act;
      // ratio and voltage only move while stepping is engaged
      if (step_act)
         s_nxt.step_out = s_r.ctrl.step_setting;
   end

   // state register
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         s_r <= '0;
         s_r.prefetch_en <= 1'b1;
         s_r.ctrl.step_setting <= STEP_SET_RESET;
      end
      else
         s_r <= s_nxt;
   end

   assign RDATA = s_r.rdata;
   assign PREFETCH_EN = s_r.prefetch_en;
   assign FLOAT_ERROR_PIN = s_r.float_error_pin;
   assign DUTY_THROTTLE = s_r.duty;
   assign STEP_THROTTLE = s_r.step;
   assign STEP_SETTING = s_r.step_out;
   assign FAST_STRINGS = s_r.ctrl.fast_strings;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // throttles trail the enable by two registers, so look three back
   property p_no_throttle_when_off;
      @(posedge CLK) disable iff (!NRST)
      !s_r.ctrl.auto_thermal_en [*3] |-> !DUTY_THROTTLE && !STEP_THROTTLE;
   endproperty
   a_no_throttle_when_off: assert property (p_no_throttle_when_off)
      else $error("throttle active while thermal enable is off");

   property p_duty_mode;
      @(posedge CLK) disable iff (!NRST)
      (s_r.ctrl.auto_thermal_en && !s_r.ctrl.mode_select && THERM_HOT)
         ##1 $stable(s_r.ctrl) |=> DUTY_THROTTLE && !STEP_THROTTLE;
   endproperty
   a_duty_mode: assert property (p_duty_mode)
      else $error("duty throttle not engaged in duty mode");

   property p_prefetch;
      @(posedge CLK) disable iff (!NRST)
      WR && ADDR == MISC_EN_ADDR ##2 !(WR && ADDR == MISC_EN_ADDR)
         |-> PREFETCH_EN == !$past(WDATA[PREFETCH_DIS_BIT], 2);
   endproperty
   a_prefetch: assert property (p_prefetch)
      else $error("prefetch enable does not follow disable bit");

   property p_float_error_pin;
      @(posedge CLK) disable iff (!NRST)
      s_r.ctrl.float_error_pin_mux |=> FLOAT_ERROR_PIN == $past(BREAK_PENDING);
   endproperty
   a_float_error_pin: assert property (p_float_error_pin)
      else $error("error pin not following break event");

   property p_step_value;
      @(posedge CLK) disable iff (!NRST)
      $rose(STEP_THROTTLE) ##1 STEP_THROTTLE
         |-> STEP_SETTING == $past(s_r.ctrl.step_setting, 2);
   endproperty
   a_step_value: assert property (p_step_value)
      else $error("step setting not applied");

   property p_step_hold;
      @(posedge CLK) disable iff (!NRST)
      !s_r.ctrl.freq_step_en [*3] |-> $stable(STEP_SETTING);
   endproperty
   a_step_hold: assert property (p_step_hold)
      else $error("ratio changed with step enable clear");

   property p_ro_bits;
      @(posedge CLK) disable iff (!NRST)
      RD && ADDR == MISC_EN_ADDR |=>
         RDATA[PERFMON_AVAIL_BIT] && RDATA[BTS_UNAVAIL_BIT]
         && RDATA[PEBS_UNAVAIL_BIT];
   endproperty
   a_ro_bits: assert property (p_ro_bits)
      else $error("availability bits wrong");

   property p_reserved;
      @(posedge CLK) disable iff (!NRST)
      RD && ADDR == THERM_CTL_ADDR |=> RDATA[63:17] == 47'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits read nonzero");

   property p_float_error_pin_legacy;
      @(posedge CLK) disable iff (!NRST)
      !s_r.ctrl.float_error_pin_mux |=> FLOAT_ERROR_PIN == $past(LEGACY_FP_ERR);
   endproperty
   a_float_error_pin_legacy: assert property (p_float_error_pin_legacy)
      else $error("error pin not following legacy source");

   // step mode must never fall back to duty modulation
   property p_step_no_duty;
      @(posedge CLK) disable iff (!NRST)
      (s_r.ctrl.auto_thermal_en && s_r.ctrl.mode_select)
         ##1 $stable(s_r.ctrl) |=> !DUTY_THROTTLE;
   endproperty
   a_step_no_duty: assert property (p_step_no_duty)
      else $error("duty throttle active in step mode");

   // stepping needs its own enable seen two registers back
   property p_step_needs_enable;
      @(posedge CLK) disable iff (!NRST)
      !s_r.ctrl.freq_step_en [*3] |-> !STEP_THROTTLE;
   endproperty
   a_step_needs_enable: assert property (p_step_needs_enable)
      else $error("step throttle engaged with step enable clear");

endmodule

// ===== logic/thermal_misc_pkg.sv
package thermal_misc_pkg;

   // ----------------------------------------------------------------
   // register map (printed offsets are not all multiples of four, so the
   // printed offset is the index and the byte address is four times it)
   // ----------------------------------------------------------------
   localparam logic [11:0] THERM_CTL_IDX = 12'h19D;
   localparam logic [11:0] MISC_EN_IDX = 12'h1A0;
   localparam logic [13:0] THERM_CTL_ADDR = {THERM_CTL_IDX, 2'b00};
   localparam logic [13:0] MISC_EN_ADDR = {MISC_EN_IDX, 2'b00};
   localparam logic [13:0] SENSOR_ADDR = 14'h0700;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MODE_SEL_BIT = 16;
   localparam int STEP_SET_MSB = 15;
   localparam int FAST_STR_BIT = 0;
   localparam int AUTO_THERM_BIT = 3;
   localparam int PERFMON_AVAIL_BIT = 7;
   localparam int PREFETCH_DIS_BIT = 9;
   localparam int FLOAT_ERROR_PIN_MUX_BIT = 10;
   localparam int BTS_UNAVAIL_BIT = 11;
   localparam int PEBS_UNAVAIL_BIT = 12;
   localparam int FREQ_STEP_EN_BIT = 13;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [63:0] MISC_RO_VALUE = 64'h0000_0000_0000_1880;
   localparam logic [63:0] MISC_RW_MASK = 64'h0000_0000_0000_2609;
   localparam logic [15:0] STEP_SET_RESET = 16'h0000;

   // throttle mechanism selected by the hardware
   typedef enum logic [1:0] {THR_NONE, THR_DUTY, THR_STEP} throttle_t;

   // software writable control state
   typedef struct packed {
      logic mode_select;
      logic [15:0] step_setting;
      logic fast_strings;
      logic auto_thermal_en;
      logic prefetch_dis;
      logic float_error_pin_mux;
      logic freq_step_en;
   } ctrl_t;

   // plain register port request
   typedef struct packed {
      logic [13:0] addr;
      logic [63:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// ===== logic/throttle_select.sv
module throttle_select
   import thermal_misc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input ctrl_t ctrl,
   input wire logic hot,
   output throttle_t mode,
   output logic duty_active,
   output logic step_active
);

   typedef struct packed {
      throttle_t mode;
      logic duty;
      logic step;
   } sel_state_t;

   sel_state_t s_r;
   sel_state_t s_nxt;

   // -----------------------------------------------
   // mechanism choice
   // -----------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.duty = 1'b0;
      s_nxt.step = 1'b0;
      if (!ctrl.auto_thermal_en)
      begin
         s_nxt.mode = THR_NONE;
      end
      else if (ctrl.mode_select)
      begin
         s_nxt.mode = THR_STEP;
         // step throttling only engages when its own enable is set
         s_nxt.step = hot && ctrl.freq_step_en;
      end
      else
      begin
         s_nxt.mode = THR_DUTY;
         s_nxt.duty = hot;
      end
   end

   // state register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         s_r <= '{mode: THR_NONE, duty: 1'b0, step: 1'b0};
      else
         s_r <= s_nxt;
   end

   assign mode = s_r.mode;
   assign duty_active = s_r.duty;
   assign step_active = s_r.step;

endmodule

// ===== tb/testbench.sv
module testbench
   import thermal_misc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [13:0] addr = 14'h0000;
   logic [63:0] wdata = 64'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic hot = 1'b0;
   logic brk = 1'b0;
   logic legacy = 1'b0;
   logic [63:0] rdata;
   logic prefetch_en;
   logic float_error_pin_pin;
   logic duty;
   logic step;
   logic [15:0] step_set;
   logic fast_str;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;

   // 20 MHz core clock
   always #25 clk = ~clk;

   thermal_misc_ctrl u_thermal_misc_ctrl (
      .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .THERM_HOT(hot), .BREAK_PENDING(brk),
      .LEGACY_FP_ERR(legacy), .RDATA(rdata), .PREFETCH_EN(prefetch_en),
      .FLOAT_ERROR_PIN(float_error_pin_pin), .DUTY_THROTTLE(duty),
      .STEP_THROTTLE(step), .STEP_SETTING(step_set),
      .FAST_STRINGS(fast_str)
   );

   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task summarize;
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe, changed just after the edge
   task wr_reg(input logic [13:0] a, input logic [63:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task rd_chk(input logic [13:0] a, input logic [63:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   // throttles lag their cause by two registers, so wait past that
   task settle;
      repeat (4) @(posedge clk);
      #1;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      rd_chk(MISC_EN_ADDR, MISC_RO_VALUE);
      rd_chk(THERM_CTL_ADDR, 64'h0);
      chk(prefetch_en, 64'h1);
      chk({duty, step}, 64'h0);
   endtask

   // all-ones writes show which bits really stick
   task t_regs;
      wr_reg(MISC_EN_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
      rd_chk(MISC_EN_ADDR, MISC_RO_VALUE | MISC_RW_MASK);
      settle();
      chk(prefetch_en, 64'h0);
      chk(fast_str, 64'h1);
      wr_reg(THERM_CTL_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
      rd_chk(THERM_CTL_ADDR, 64'h1_FFFF);
      rd_chk(14'h0004, 64'h0);
      wr_reg(MISC_EN_ADDR, 64'h2000);
      rd_chk(MISC_EN_ADDR, MISC_RO_VALUE | 64'h2000);
      settle();
      chk(prefetch_en, 64'h1);
   endtask

   // every combination of both pin sources under both mux settings
   task t_float_error_pin;
      for (int m = 0; m < 2; m++)
      begin
         wr_reg(MISC_EN_ADDR, m ? 64'h2400 : 64'h2000);
         for (int i = 0; i < 4; i++)
         begin
            @(posedge clk);
            brk <= i[0];
            legacy <= i[1];
            settle();
            chk(float_error_pin_pin, (m == 1) ? i[0] : i[1]);
         end
      end
   endtask

   task t_throttle;
      @(posedge clk);
      hot <= 1'b1;
      wr_reg(THERM_CTL_ADDR, 64'h1_A5C3);
      settle();
      chk({duty, step}, 64'h0);
      chk(step_set, 64'h0);
      wr_reg(MISC_EN_ADDR, 64'h2008);
      settle();
      chk({duty, step}, 64'h1);
      chk(step_set, 64'hA5C3);
      rd_chk(SENSOR_ADDR, 64'hA);
      wr_reg(THERM_CTL_ADDR, 64'h1_0F0F);
      settle();
      chk(step_set, 64'h0F0F);
      wr_reg(MISC_EN_ADDR, 64'h0008);
      settle();
      chk({duty, step}, 64'h0);
      chk(step_set, 64'h0F0F);
      wr_reg(THERM_CTL_ADDR, 64'h0);
      settle();
      chk({duty, step}, 64'h2);
      rd_chk(SENSOR_ADDR, 64'h5);
      wr_reg(MISC_EN_ADDR, 64'h2000);
      settle();
      chk({duty, step}, 64'h0);
      rd_chk(SENSOR_ADDR, 64'h0);
      @(posedge clk);
      hot <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // hang guard and main sequence
   // ---------------------------------------------------------------
   // the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         summarize();
      end
   end

   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_regs();
      t_float_error_pin();
      t_throttle();
      summarize();
   end
endmodule
